// [dmaru_top.sv]
// What this block does
// - Drive current address, then update it
// - Source field: fixed, offset, increment, decrement
// - Destination field: fixed, offset, increment, decrement
// - Size code picks step 1, 2, 4
// - Misaligned reads split, item ends at start+step
// - Misaligned writes split, item ends at start+step
// - Source reloads start on block end
// - Destination reloads start on block end
// - Repeat area keeps upper address bits
// - Counter drops by bytes moved
// - Zero counter stays zero, unlimited
// - CPU write wins; a control write setting enable overrides a stop
// - High half reload, low half counter
// - Counter one-to-zero loads reload size
// - Hardware clears enable on listed events
// - Offset added per item regardless size
`timescale 1ns/1ns
`default_nettype none
`include "dmaru_cfg.svh"
module dmaru_top (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [1:0]  xferReq,
  input  wire logic        busAck,
  input  wire logic        nmi,
  input  wire logic        addrError,
  input  wire logic        standby,
  output logic      [31:0] busAddr,
  output logic      [1:0]  busSize,
  output logic             busRead,
  output logic             busWrite,
  output logic             busChannel,
  output logic      [1:0]  channelEnable
);
  dmaru_pkg::dmaru_regs_t st;
  dmaru_pkg::dmaru_regs_t next_st;
  dmaru_pkg::dmaru_chan_t cc;
  logic [31:0] srcNext;
  logic        srcOvf;
  logic [31:0] dstNext;
  logic        dstOvf;
  logic [31:0] cntNext;
  logic        cntZero;
  logic [31:0] blkNext;
  logic        blkWrap;
  logic        blockish;
  logic        srcReload;
  logic        dstReload;

  // Sub-access size from alignment and bytes left in the item
  function automatic logic [1:0] subSize(input logic [31:0] addr, input logic [2:0] left);
    if (left >= 3'h4 && addr[1:0] == 2'h0) begin
      subSize = 2'h2;
    end else if (left >= 3'h2 && addr[0] == 1'b0) begin
      subSize = 2'h1;
    end else begin
      subSize = 2'h0;
    end
  endfunction

  function automatic logic [31:0] readReg(input dmaru_pkg::dmaru_chan_t c, input logic [4:0] ofs,
                                          input logic act);
    unique case (ofs)
      `DMARU_OFS_SRC:    readReg = c.src;
      `DMARU_OFS_DST:    readReg = c.dst;
      `DMARU_OFS_CNT:    readReg = c.cnt;
      `DMARU_OFS_BLK:    readReg = c.blk;
      `DMARU_OFS_OFFSET: readReg = c.ofs;
      `DMARU_OFS_CTL: begin
        readReg = c.ctl;
        readReg[`DMARU_ACT_BIT] = act;
      end
      default:           readReg = 32'h0;
    endcase
  endfunction

  assign cc = st.ch[st.cur];
  assign blockish = cc.ctl[`DMARU_MODE_LSB +: 2] != `DMARU_MODE_NORMAL;
  assign srcReload = blockish && !cc.ctl[`DMARU_SIDE_BIT] && blkWrap;
  assign dstReload = blockish && cc.ctl[`DMARU_SIDE_BIT] && blkWrap;

  dmaru_addr_step srcStep (
    .itemStart (st.itemStart),
    .xferStart (cc.srcStart),
    .offset    (cc.ofs),
    .upd       (cc.ctl[`DMARU_SUPD_LSB +: 2]),
    .size      (cc.ctl[`DMARU_SIZE_LSB +: 2]),
    .area      (cc.ctl[`DMARU_SAREA_LSB +: 5]),
    .reload    (srcReload),
    .nextAddr  (srcNext),
    .overflow  (srcOvf)
  );

  dmaru_addr_step dstStep (
    .itemStart (st.itemStart),
    .xferStart (cc.dstStart),
    .offset    (cc.ofs),
    .upd       (cc.ctl[`DMARU_DUPD_LSB +: 2]),
    .size      (cc.ctl[`DMARU_SIZE_LSB +: 2]),
    .area      (cc.ctl[`DMARU_DAREA_LSB +: 5]),
    .reload    (dstReload),
    .nextAddr  (dstNext),
    .overflow  (dstOvf)
  );

  dmaru_count_step cntStep (
    .cnt     (cc.cnt),
    .blk     (cc.blk),
    .size    (cc.ctl[`DMARU_SIZE_LSB +: 2]),
    .nextCnt (cntNext),
    .hitZero (cntZero),
    .nextBlk (blkNext),
    .blkWrap (blkWrap)
  );

  always_comb begin
    logic [2:0]  subBytes;
    logic [31:0] wdat;
    logic        ch;
    logic [31:0] ctlNew;
    logic        act;
    subBytes = 3'h0;
    wdat = 32'h0;
    ch = 1'b0;
    ctlNew = 32'h0;
    act = 1'b0;
    next_st = st;
    next_st.hreadyout = 1'b1;
    subBytes = dmaru_pkg::sizeBytes(st.busSize);
    unique case (st.fsm)
      dmaru_pkg::DMARU_IDLE: begin
        if (xferReq[0] && st.ch[0].ctl[`DMARU_EN_BIT]) begin
          ch = 1'b0;
        end else begin
          ch = 1'b1;
        end
        if (xferReq[ch] && st.ch[ch].ctl[`DMARU_EN_BIT]) begin
          next_st.cur = ch;
          next_st.left = dmaru_pkg::sizeBytes(st.ch[ch].ctl[`DMARU_SIZE_LSB +: 2]);
          next_st.itemStart = st.ch[ch].src;
          next_st.busAddr = st.ch[ch].src;
          next_st.busSize = subSize(st.ch[ch].src, next_st.left);
          next_st.busRead = 1'b1;
          next_st.ovfPend = 1'b0;
          next_st.fsm = dmaru_pkg::DMARU_READ;
        end
      end
      dmaru_pkg::DMARU_READ: begin
        if (busAck) begin
          next_st.left = st.left - subBytes;
          if (st.left == subBytes) begin
            next_st.ch[st.cur].src = srcNext;
            next_st.ovfPend = srcOvf && cc.ctl[`DMARU_SAIE_BIT];
            next_st.left = dmaru_pkg::sizeBytes(cc.ctl[`DMARU_SIZE_LSB +: 2]);
            next_st.itemStart = cc.dst;
            next_st.busAddr = cc.dst;
            next_st.busSize = subSize(cc.dst, next_st.left);
            next_st.busRead = 1'b0;
            next_st.busWrite = 1'b1;
            next_st.fsm = dmaru_pkg::DMARU_WRITE;
          end else begin
            next_st.ch[st.cur].src = cc.src + {29'h0, subBytes};
            next_st.busAddr = cc.src + {29'h0, subBytes};
            next_st.busSize = subSize(next_st.busAddr, next_st.left);
          end
        end
      end
      dmaru_pkg::DMARU_WRITE: begin
        if (busAck) begin
          next_st.left = st.left - subBytes;
          if (st.left == subBytes) begin
            next_st.ch[st.cur].dst = dstNext;
            next_st.ch[st.cur].cnt = cntNext;
            if (blockish) begin
              next_st.ch[st.cur].blk = blkNext;
            end
            next_st.busWrite = 1'b0;
            next_st.fsm = dmaru_pkg::DMARU_IDLE;
            if (cntZero) begin
              next_st.ch[st.cur].ctl[`DMARU_EN_BIT] = 1'b0;
              next_st.ch[st.cur].ctl[`DMARU_DONE_BIT] = 1'b1;
            end
            if ((blkWrap && cc.ctl[`DMARU_MODE_LSB +: 2] == `DMARU_MODE_REPEAT) || st.ovfPend
                || (dstOvf && cc.ctl[`DMARU_DAIE_BIT])) begin
              next_st.ch[st.cur].ctl[`DMARU_EN_BIT] = 1'b0;
              next_st.ch[st.cur].ctl[`DMARU_ESC_BIT] = 1'b1;
            end
          end else begin
            next_st.ch[st.cur].dst = cc.dst + {29'h0, subBytes};
            next_st.busAddr = cc.dst + {29'h0, subBytes};
            next_st.busSize = subSize(next_st.busAddr, next_st.left);
          end
        end
      end
      default: begin
        next_st.fsm = dmaru_pkg::DMARU_IDLE;
        next_st.busRead = 1'b0;
        next_st.busWrite = 1'b0;
      end
    endcase
    if (nmi || addrError || standby) begin
      for (int i = 0; i < 2; i++) begin
        next_st.ch[i].ctl[`DMARU_EN_BIT] = 1'b0;
      end
      if (nmi || addrError) begin
        next_st.ch[0].ctl[`DMARU_ERR_BIT] = 1'b1;
      end
    end
    if (st.dValid && st.dWrite && st.dAddr[7:6] == 2'h0) begin
      ch = st.dAddr[`DMARU_CH_BIT];
      wdat = hwdata;
      unique case (st.dAddr[4:0])
        `DMARU_OFS_SRC:    next_st.ch[ch].src = wdat;
        `DMARU_OFS_DST:    next_st.ch[ch].dst = wdat;
        `DMARU_OFS_CNT:    next_st.ch[ch].cnt = wdat;
        `DMARU_OFS_BLK:    next_st.ch[ch].blk = wdat;
        `DMARU_OFS_OFFSET: next_st.ch[ch].ofs = wdat;
        `DMARU_OFS_CTL: begin
          ctlNew = (wdat & `DMARU_CTL_WMASK) | (next_st.ch[ch].ctl & ~`DMARU_CTL_WMASK);
          if (!wdat[`DMARU_EN_BIT]) begin
            ctlNew[`DMARU_EN_BIT] = 1'b0;
          end else if (!st.ch[ch].ctl[`DMARU_EN_BIT]) begin
            ctlNew[`DMARU_DONE_BIT] = 1'b0;
            ctlNew[`DMARU_ESC_BIT] = 1'b0;
            next_st.ch[ch].srcStart = next_st.ch[ch].src;
            next_st.ch[ch].dstStart = next_st.ch[ch].dst;
          end
          next_st.ch[ch].ctl = ctlNew;
        end
        default: begin
        end
      endcase
    end
    // AHB-Lite address phase capture
    next_st.dValid = hsel && htrans[1] && hready;
    if (next_st.dValid) begin
      next_st.dAddr = haddr[7:0];
      next_st.dWrite = hwrite;
    end
    if (next_st.dValid && !hwrite) begin
      ch = haddr[`DMARU_CH_BIT];
      act = next_st.fsm != dmaru_pkg::DMARU_IDLE && next_st.cur == ch;
      if (haddr[31:6] == 26'h0) begin
        next_st.hrdata = readReg(next_st.ch[ch], haddr[4:0], act);
      end else begin
        next_st.hrdata = 32'h0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int i = 0; i < 2; i++) begin
        st.ch[i] <= '{default: `DMARU_RST_WORD};
      end
      st.fsm <= dmaru_pkg::DMARU_IDLE;
      st.cur <= 1'b0;
      st.left <= 3'h0;
      st.itemStart <= 32'h0;
      st.ovfPend <= 1'b0;
      st.busAddr <= 32'h0;
      st.busSize <= 2'h0;
      st.busRead <= 1'b0;
      st.busWrite <= 1'b0;
      st.dAddr <= 8'h0;
      st.dWrite <= 1'b0;
      st.dValid <= 1'b0;
      st.hrdata <= 32'h0;
      st.hreadyout <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign hrdata = st.hrdata;
  assign hreadyout = st.hreadyout;
  assign hresp = 1'b0;
  assign busAddr = st.busAddr;
  assign busSize = st.busSize;
  assign busRead = st.busRead;
  assign busWrite = st.busWrite;
  assign busChannel = st.cur;
  assign channelEnable = {st.ch[1].ctl[`DMARU_EN_BIT], st.ch[0].ctl[`DMARU_EN_BIT]};
endmodule
`default_nettype wire

// [dmaru_cfg.svh]
`ifndef DMARU_CFG_SVH
`define DMARU_CFG_SVH

// Register offsets inside one channel window, byte addresses
`define DMARU_OFS_SRC      5'h00
`define DMARU_OFS_DST      5'h04
`define DMARU_OFS_CNT      5'h08
`define DMARU_OFS_BLK      5'h0c
`define DMARU_OFS_OFFSET   5'h10
`define DMARU_OFS_CTL      5'h14
// Channel window size is 32 bytes, channel 1 starts at 0x20
`define DMARU_CH_BIT       5

// Control register field positions
`define DMARU_EN_BIT       0
`define DMARU_SIZE_LSB     1
`define DMARU_SUPD_LSB     4
`define DMARU_DUPD_LSB     6
`define DMARU_MODE_LSB     8
`define DMARU_SIDE_BIT     10
`define DMARU_SAREA_LSB    11
`define DMARU_DAREA_LSB    16
`define DMARU_SAIE_BIT     21
`define DMARU_DAIE_BIT     22
`define DMARU_ACT_BIT      24
`define DMARU_DONE_BIT     25
`define DMARU_ESC_BIT      26
`define DMARU_ERR_BIT      27
// Bits that software may write in the control register
`define DMARU_CTL_WMASK    32'h007fffff

// Transfer modes
`define DMARU_MODE_NORMAL  2'h0
`define DMARU_MODE_REPEAT  2'h1
`define DMARU_MODE_BLOCK   2'h2

// Reset values
`define DMARU_RST_WORD     32'h00000000

`endif

// [dmaru_pkg.sv]
package dmaru_pkg;

  typedef enum logic [2:0] {
    DMARU_IDLE  = 3'b001,
    DMARU_READ  = 3'b010,
    DMARU_WRITE = 3'b100
  } dmaru_state_t;

  typedef struct packed {
    logic [31:0] src;
    logic [31:0] dst;
    logic [31:0] cnt;
    logic [31:0] blk;
    logic [31:0] ofs;
    logic [31:0] ctl;
    logic [31:0] srcStart;
    logic [31:0] dstStart;
  } dmaru_chan_t;

  typedef struct packed {
    dmaru_chan_t [1:0] ch;
    dmaru_state_t      fsm;
    logic              cur;
    logic [2:0]        left;
    logic [31:0]       itemStart;
    logic              ovfPend;
    logic [31:0]       busAddr;
    logic [1:0]        busSize;
    logic              busRead;
    logic              busWrite;
    logic [7:0]        dAddr;
    logic              dWrite;
    logic              dValid;
    logic [31:0]       hrdata;
    logic              hreadyout;
  } dmaru_regs_t;

  // Bytes moved by one item of the given size code
  function automatic logic [2:0] sizeBytes(input logic [1:0] size);
    unique case (size)
      2'h0:    sizeBytes = 3'h1;
      2'h1:    sizeBytes = 3'h2;
      default: sizeBytes = 3'h4;
    endcase
  endfunction

endpackage

// [dmaru_addr_step.sv]
`timescale 1ns/1ns
`default_nettype none
module dmaru_addr_step (
  input  wire logic [31:0] itemStart,
  input  wire logic [31:0] xferStart,
  input  wire logic [31:0] offset,
  input  wire logic [1:0]  upd,
  input  wire logic [1:0]  size,
  input  wire logic [4:0]  area,
  input  wire logic        reload,
  output logic      [31:0] nextAddr,
  output logic             overflow
);
  logic [31:0] step;
  logic [31:0] moved;
  logic [31:0] mask;

  always_comb begin
    step = {29'h0, dmaru_pkg::sizeBytes(size)};
    unique case (upd)
      2'h0:    moved = itemStart;
      2'h1:    moved = itemStart + offset;
      2'h2:    moved = itemStart + step;
      default: moved = itemStart - step;
    endcase
    mask = (area == 5'h0) ? 32'hffffffff : ((32'h1 << area) - 32'h1);
    nextAddr = (itemStart & ~mask) | (moved & mask);
    overflow = (area != 5'h0) && (upd != 2'h0) && (((moved ^ itemStart) & ~mask) != 32'h0);
    if (reload) begin
      nextAddr = xferStart;
      overflow = 1'b0;
    end
  end
endmodule
`default_nettype wire

// [dmaru_count_step.sv]
`timescale 1ns/1ns
`default_nettype none
module dmaru_count_step (
  input  wire logic [31:0] cnt,
  input  wire logic [31:0] blk,
  input  wire logic [1:0]  size,
  output logic      [31:0] nextCnt,
  output logic             hitZero,
  output logic      [31:0] nextBlk,
  output logic             blkWrap
);
  logic [31:0] bytes;

  always_comb begin
    bytes = {29'h0, dmaru_pkg::sizeBytes(size)};
    if (cnt == 32'h0) begin
      nextCnt = 32'h0;
      hitZero = 1'b0;
    end else if (cnt <= bytes) begin
      nextCnt = 32'h0;
      hitZero = 1'b1;
    end else begin
      nextCnt = cnt - bytes;
      hitZero = 1'b0;
    end
    if (blk[15:0] == 16'h1) begin
      nextBlk = {blk[31:16], blk[31:16]};
      blkWrap = 1'b1;
    end else begin
      nextBlk = {blk[31:16], blk[15:0] - 16'h1};
      blkWrap = 1'b0;
    end
  end
endmodule
`default_nettype wire

// [dmaru_top_assertions.sv]
`timescale 1ns/1ns
`default_nettype none
module dmaru_top_checker (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        busAck,
  input wire logic        nmi,
  input wire logic        addrError,
  input wire logic        standby,
  input wire logic [31:0] busAddr,
  input wire logic [1:0]  busSize,
  input wire logic        busRead,
  input wire logic        busWrite,
  input wire logic [1:0]  channelEnable
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  AST_READ_HOLD: assert property (busRead && !busAck |=> busRead && $stable(busAddr) && $stable(busSize))
    else $error("read request changed before acknowledge");
  AST_WRITE_HOLD: assert property (busWrite && !busAck |=> busWrite && $stable(busAddr) && $stable(busSize))
    else $error("write request changed before acknowledge");
  AST_SIZE_CODE: assert property ((busRead || busWrite) |-> busSize != 2'h3)
    else $error("illegal access size");
  AST_READ_ALIGN: assert property (busRead |-> !(busSize == 2'h1 && busAddr[0]) && !(busSize == 2'h2 && busAddr[1:0] != 2'h0))
    else $error("misaligned read sub-access");
  AST_WRITE_ALIGN: assert property (busWrite |-> !(busSize == 2'h1 && busAddr[0]) && !(busSize == 2'h2 && busAddr[1:0] != 2'h0))
    else $error("misaligned write sub-access");
  AST_ONE_PHASE: assert property (!(busRead && busWrite))
    else $error("read and write at once");
  AST_WRITE_THEN_IDLE: assert property (busWrite && busAck |=> !busRead)
    else $error("read follows write directly");
  AST_ERROR_STOP: assert property ((nmi || addrError || standby) |-> ##[1:2] channelEnable == 2'h0)
    else $error("enable survived stop event");
  AST_RESET_QUIET: assert property ($fell(reset) |-> channelEnable == 2'h0 && !busRead && !busWrite)
    else $error("not quiet after reset");
  cover property (busRead && busAck && busSize == 2'h0);
  cover property (busWrite && busAck && busSize == 2'h2);
  cover property (nmi ##1 channelEnable == 2'h0);
endmodule
bind dmaru_top dmaru_top_checker i_chk (.ref_clk, .reset, .busAck, .nmi, .addrError, .standby, .busAddr,
  .busSize, .busRead, .busWrite, .channelEnable);
`default_nettype wire

// [dmaru_bus_model.sv]
`timescale 1ns/1ns
`default_nettype none
module dmaru_bus_model (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic busRead,
  input  wire logic busWrite,
  input  wire logic slow,
  output logic      busAck
);
  logic [1:0] waitCnt;
  always_ff @(posedge ref_clk) begin
    if (reset || busAck || !(busRead || busWrite)) begin
      busAck  <= 1'b0;
      waitCnt <= 2'h0;
    end else if (!slow || waitCnt == 2'h3) begin
      busAck <= 1'b1;
    end else begin
      waitCnt <= waitCnt + 2'h1;
    end
  end
endmodule
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench;
  typedef struct {logic [31:0] ctl, src, dst, cnt, eSrc, eDst, eCnt; logic eEn; int acks;} dmaru_row_t;
  dmaru_row_t  rows [6] = '{
    '{32'h81, 32'h100, 32'h200, 32'h10, 32'h100, 32'h201, 32'hf, 1'b1, 2},
    '{32'hd3, 32'h100, 32'h200, 32'h8, 32'hf0, 32'h1fe, 32'h6, 1'b1, 2},
    '{32'h65, 32'h100, 32'h200, 32'h0, 32'h104, 32'h1f0, 32'h0, 1'b1, 2},
    '{32'ha5, 32'h101, 32'h200, 32'h4, 32'h105, 32'h204, 32'h0, 1'b0, 4},
    '{32'h33, 32'h103, 32'h301, 32'h6, 32'h101, 32'h301, 32'h4, 1'b1, 4},
    '{32'h20a5, 32'h10c, 32'h200, 32'h8, 32'h100, 32'h204, 32'h4, 1'b1, 2}};
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  xferReq = 2'h0;
  logic        nmi = 1'b0;
  logic        slow = 1'b0;
  logic [31:0] hrdata, busAddr, rdat;
  logic        hreadyout, hresp, busAck, busRead, busWrite, busChannel;
  logic [1:0]  busSize, channelEnable;
  logic [31:0] q [$];
  int          n_errors = 0;
  int          check_count = 0;

  dmaru_top i_dut (.ref_clk(ref_clk), .reset(reset), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .xferReq(xferReq), .busAck(busAck), .nmi(nmi),
    .addrError(1'b0), .standby(1'b0), .busAddr(busAddr), .busSize(busSize), .busRead(busRead),
    .busWrite(busWrite), .busChannel(busChannel), .channelEnable(channelEnable));
  dmaru_bus_model i_bus (.ref_clk(ref_clk), .reset(reset), .busRead(busRead), .busWrite(busWrite),
    .slow(slow), .busAck(busAck));

  initial forever #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (busAck === 1'b1 && (busRead | busWrite) === 1'b1) q.push_back(busAddr);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    r = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0, rdat);
    chk(rdat, exp);
  endtask
  task automatic cfg(input logic [31:0] b, ctl, src, dst, cnt, blk);
    int k;
    wr(b + 32'h14, 32'h0);
    for (k = 0; k < 5; k++) begin
      ahb(1'b0, b + 32'h14, 32'h0, rdat);
      if (rdat[0] === 1'b0) break;
    end
    wr(b, src);
    wr(b + 32'h4, dst);
    wr(b + 32'h8, cnt);
    wr(b + 32'hc, blk);
    wr(b + 32'h10, 32'hfffffff0);
    wr(b + 32'h14, ctl);
  endtask
  task automatic run(input int ch);
    int i;
    q.delete();
    xferReq[ch] <= 1'b1;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (busRead !== 1'b1 && i < 50);
    xferReq <= 2'h0;
    chk(busChannel, ch);
    do @(posedge ref_clk); while ((busRead | busWrite) !== 1'b0);
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #2000000;
    n_errors++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    rd(32'h0, 32'h0);
    rd(32'h14, 32'h0);
    chk(channelEnable, 32'h0);
    for (int i = 0; i < 6; i++) begin
      cfg(32'h0, rows[i].ctl, rows[i].src, rows[i].dst, rows[i].cnt, 32'h0);
      run(0);
      chk(q.size(), rows[i].acks);
      chk(q[0], rows[i].src);
      rd(32'h0, rows[i].eSrc);
      rd(32'h4, rows[i].eDst);
      rd(32'h8, rows[i].eCnt);
      chk(channelEnable[0], rows[i].eEn);
    end
    slow <= 1'b1;
    cfg(32'h0, 32'h1a1, 32'h100, 32'h200, 32'h10, 32'h00020002);
    run(0);
    rd(32'hc, 32'h00020001);
    run(0);
    rd(32'hc, 32'h00020002);
    rd(32'h0, 32'h100);
    chk(channelEnable[0], 1'b0);
    cfg(32'h0, 32'h5a1, 32'h100, 32'h200, 32'h10, 32'h00010001);
    run(0);
    rd(32'h4, 32'h200);
    slow <= 1'b0;
    cfg(32'h20, 32'ha5, 32'h400, 32'h500, 32'h0, 32'h0);
    run(1);
    rd(32'h20, 32'h404);
    rd(32'h0, 32'h101);
    nmi <= 1'b1;
    @(posedge ref_clk);
    nmi <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk(channelEnable, 32'h0);
    ahb(1'b0, 32'h14, 32'h0, rdat);
    chk(rdat[27], 1'b1);
    wr(32'h18, 32'hffffffff);
    rd(32'h18, 32'h0);
    chk({hresp, hreadyout}, 32'h1);
    rd(32'h40, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
